// *** pkg/lot_pkg.sv ***
// Purpose: shared constants and carrier types for the lo/if tuning register bank
// Assumes: 8-bit register addresses and data from the serial protocol engine
// Notes:   every writable register keeps its reserved bits at zero
package lot_pkg;

   // register offsets
   localparam logic [7:0] DBL_OFS      = 8'h21;
   localparam logic [7:0] QUAD_OFS     = 8'h22;
   localparam logic [7:0] FWD_GAIN_OFS = 8'h23;
   localparam logic [7:0] REV_GAIN_OFS = 8'h24;
   localparam logic [7:0] CORNER_OFS   = 8'h25;
   localparam logic [7:0] TEMP_OFS     = 8'h26;

   // writable bits of each register, reserved bits are zero in the mask
   localparam logic [7:0] DBL_MASK     = 8'h1F;
   localparam logic [7:0] QUAD_MASK    = 8'h0F;
   localparam logic [7:0] GAIN_MASK    = 8'h7F;
   localparam logic [7:0] CORNER_MASK  = 8'hFF;
   localparam logic [7:0] TEMP_MASK    = 8'h1F;

   // field positions
   localparam int DBL_MSB       = 4;
   localparam int QUAD_MSB      = 3;
   localparam int GAIN_MSB      = 6;
   localparam int NARROW_LSB    = 4;
   localparam int NARROW_MSB    = 7;
   localparam int WIDE_MSB      = 3;
   localparam int TEMP_MSB      = 4;

   // reset values
   localparam logic [7:0] REG_RST      = 8'h00;
   localparam logic [4:0] TEMP_RST     = 5'h00;

   // gain code equals gain in db, applied in steps of this size
   localparam int GAIN_STEP_DB  = 6;
   // sensor scale in milli-degrees celsius
   localparam int TEMP_STEP_MDEGC  = 7400;
   localparam int TEMP_FIRST_MDEGC = -44600;

   // writable register table, one entry per register
   localparam int NUM_WR = 5;
   localparam logic [7:0] WR_OFS  [NUM_WR] = '{DBL_OFS, QUAD_OFS, FWD_GAIN_OFS,
                                               REV_GAIN_OFS, CORNER_OFS};
   localparam logic [7:0] WR_MASK [NUM_WR] = '{DBL_MASK, QUAD_MASK, GAIN_MASK,
                                               GAIN_MASK, CORNER_MASK};
   localparam int IDX_DBL    = 0;
   localparam int IDX_QUAD   = 1;
   localparam int IDX_FWD_GAIN = 2;
   localparam int IDX_REV_GAIN = 3;
   localparam int IDX_CORNER = 4;

   // register access from the serial engine
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } lot_req_t;

   // tuning codes handed to the analog blocks
   typedef struct packed {
      logic [4:0] doubler_filter_tune;
      logic [3:0] quad_filter_tune;
      logic [6:0] forward_if_gain;
      logic [6:0] reverse_if_gain;
      logic [3:0] narrow_if_corner;
      logic [3:0] wide_if_corner;
   } lot_tune_t;

endpackage

// *** verilog/lot_field_reg.sv ***
// Purpose: one 8-bit writable register with a mask of writable bits
// Assumes: write strobe is a single-cycle pulse on clk_sys_in
// Notes:   bits outside the mask hold their reset value and ignore writes
`timescale 1ns/1ps
`default_nettype none
module lot_field_reg #(
   parameter logic [7:0] MASK = 8'hFF,
   parameter logic [7:0] RST  = 8'h00
) (
   input  wire logic       clk_sys_in,  // system clock
   input  wire logic       rstn_in,     // async reset, active low
   input  wire logic       we_in,       // write strobe
   input  wire logic [7:0] wdata_in,    // write data
   output logic      [7:0] q_out        // stored value
);
   logic [7:0] q_q;
   wire  [7:0] q_d = we_in ? (wdata_in & MASK) : q_q;

   // masked storage
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         q_q <= RST & MASK;
      end else begin
         q_q <= q_d;
      end
   end

   assign q_out = q_q;

   chk_masked_bits: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (q_q & ~MASK) == 8'h00) else $error("reserved bit set in field register");
endmodule // lot_field_reg
`default_nettype wire

// *** verilog/lot_temp_sync.sv ***
// Purpose: bring the sensor code into the clock domain and hold a clean copy
// Assumes: the sensor code changes slowly compared with clk_sys_in
// Notes:   a new code is taken only when two synced samples agree
`timescale 1ns/1ps
`default_nettype none
module lot_temp_sync (
   input  wire logic       clk_sys_in,  // system clock
   input  wire logic       rstn_in,     // async reset, active low
   input  wire logic [4:0] sensor_in,   // raw thermometer code, asynchronous
   output logic      [4:0] code_out     // stable thermometer code
);
   import lot_pkg::*;

   logic [4:0] sync1_q;
   logic [4:0] sync2_q;
   logic [4:0] prev_q;
   logic [4:0] code_q;
   wire        agree = (sync2_q == prev_q);

   // two-flop synchroniser, then an agreement filter against bit skew
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sync1_q <= TEMP_RST;
         sync2_q <= TEMP_RST;
         prev_q  <= TEMP_RST;
         code_q  <= TEMP_RST;
      end else begin
         sync1_q <= sensor_in;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
         code_q  <= agree ? sync2_q : code_q;
      end
   end

   assign code_out = code_q;

   chk_temp_filter: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      !$stable(code_q) |-> $past(sync2_q) == $past(prev_q)) else $error("temp code took unsettled sample");
endmodule // lot_temp_sync
`default_nettype wire

// *** verilog/lot_reg_bank.sv ***
// Purpose: lo filter tuning, if gain, if corner and thermometer registers
// Assumes: the serial engine delivers one-cycle read and write strobes on clk_sys_in
// Notes:   reads answer one cycle after the strobe; unmapped reads return zero
//
// Function
// - A 5-bit read-write code, zero at reset, tunes the filter in the lo doubler.
// - The low 4 bits at 0x22 are a read-write code, zero at reset, tuning the lo quadrupler filter.
// - At 0x23 a 7-bit read-write forward if gain code, zero at reset, equals gain in db in 6 db steps.
// - At 0x24 a 7-bit read-write reverse if gain code, zero at reset, uses the same encoding.
// - The upper 4 bits at 0x25 are a read-write narrow-band if filter corner code, zero at reset.
// - The lower 4 bits at 0x25 are a read-write wideband if filter corner code, zero at reset.
// - At 0x26 a read-only 5-bit thermometer code reads about 7.4 c per step, first step at -44.6 c.
// - The doubler code lives at 0x21 and bits 7 to 5 there are reserved and read-only.
`timescale 1ns/1ps
`default_nettype none
module lot_reg_bank (
   input  wire logic              clk_sys_in,   // system clock, 25 mhz
   input  wire logic              rstn_in,      // async reset, active low
   input  wire lot_pkg::lot_req_t req_in,       // register request from serial engine
   input  wire logic [4:0]        temp_sense_in, // raw thermometer code, asynchronous
   output logic      [7:0]        rd_data_out,  // read data, registered
   output logic                   rd_valid_out, // read data valid pulse
   output logic                   rd_hit_out,   // read hit a mapped register
   output lot_pkg::lot_tune_t     tune_out      // tuning codes to analog blocks
);
   import lot_pkg::*;

   // stored register images, reserved bits already zero
   logic [7:0] reg_val [NUM_WR];
   logic [4:0] temp_code;

   // read path state
   logic [7:0] rd_data_q;
   logic [7:0] rd_data_d;
   logic       rd_valid_q;
   logic       rd_hit_q;
   logic       rd_hit_d;

   // address decode for the thermometer register
   wire        sel_temp  = (req_in.addr == TEMP_OFS);
   wire [7:0]  temp_word = {3'h0, temp_code};

   // one masked register per writable offset
   genvar gi;
   generate
      for (gi = 0; gi < NUM_WR; gi++) begin : g_reg
         wire sel = (req_in.addr == WR_OFS[gi]);
         wire we  = req_in.wr & sel;
         lot_field_reg #(
            .MASK (WR_MASK[gi]),
            .RST  (REG_RST)
         ) u_reg (
            .clk_sys_in (clk_sys_in),
            .rstn_in    (rstn_in),
            .we_in      (we),
            .wdata_in   (req_in.wdata),
            .q_out      (reg_val[gi])
         );
      end
   endgenerate

   // thermometer code is only ever read, writes to its offset are dropped
   lot_temp_sync u_temp (
      .clk_sys_in (clk_sys_in),
      .rstn_in    (rstn_in),
      .sensor_in  (temp_sense_in),
      .code_out   (temp_code)
   );

   // read decode, one named select per mapped offset
   wire        sel_dbl    = (req_in.addr == DBL_OFS);
   wire        sel_quad   = (req_in.addr == QUAD_OFS);
   wire        sel_fwd    = (req_in.addr == FWD_GAIN_OFS);
   wire        sel_rev    = (req_in.addr == REV_GAIN_OFS);
   wire        sel_corner = (req_in.addr == CORNER_OFS);

   // read select, each image gated by its select, unmapped offsets answer zero
   assign rd_hit_d  = sel_dbl | sel_quad | sel_fwd | sel_rev | sel_corner | sel_temp;
   assign rd_data_d = ({8{sel_dbl}}    & reg_val[IDX_DBL])
                    | ({8{sel_quad}}   & reg_val[IDX_QUAD])
                    | ({8{sel_fwd}}    & reg_val[IDX_FWD_GAIN])
                    | ({8{sel_rev}}    & reg_val[IDX_REV_GAIN])
                    | ({8{sel_corner}} & reg_val[IDX_CORNER])
                    | ({8{sel_temp}}   & temp_word);

   // read data register, loaded on the read strobe
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rd_data_q  <= REG_RST;
         rd_valid_q <= 1'b0;
         rd_hit_q   <= 1'b0;
      end else begin
         rd_data_q  <= req_in.rd ? rd_data_d : rd_data_q;
         rd_valid_q <= req_in.rd;
         rd_hit_q   <= req_in.rd ? rd_hit_d : rd_hit_q;
      end
   end

   assign rd_data_out  = rd_data_q;
   assign rd_valid_out = rd_valid_q;
   assign rd_hit_out   = rd_hit_q;

   // tuning fields out of the register images
   assign tune_out = '{
      doubler_filter_tune: reg_val[IDX_DBL][DBL_MSB:0],
      quad_filter_tune:    reg_val[IDX_QUAD][QUAD_MSB:0],
      forward_if_gain:     reg_val[IDX_FWD_GAIN][GAIN_MSB:0],
      reverse_if_gain:     reg_val[IDX_REV_GAIN][GAIN_MSB:0],
      narrow_if_corner:    reg_val[IDX_CORNER][NARROW_MSB:NARROW_LSB],
      wide_if_corner:      reg_val[IDX_CORNER][WIDE_MSB:0]
   };

   // checks: each write lands in its field one cycle later

   chk_doubler_write: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (req_in.wr && req_in.addr == DBL_OFS) |=>
         tune_out.doubler_filter_tune == $past(req_in.wdata[DBL_MSB:0]))
      else $error("doubler code did not take write");

   chk_quad_write: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (req_in.wr && req_in.addr == QUAD_OFS) |=>
         tune_out.quad_filter_tune == $past(req_in.wdata[QUAD_MSB:0]))
      else $error("quadrupler code did not take write");

   chk_fwd_gain_write: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (req_in.wr && req_in.addr == FWD_GAIN_OFS) |=>
         tune_out.forward_if_gain == $past(req_in.wdata[GAIN_MSB:0]))
      else $error("forward gain did not take write");

   chk_rev_gain_write: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (req_in.wr && req_in.addr == REV_GAIN_OFS) |=>
         tune_out.reverse_if_gain == $past(req_in.wdata[GAIN_MSB:0]))
      else $error("reverse gain did not take write");

   chk_narrow_write: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (req_in.wr && req_in.addr == CORNER_OFS) |=>
         tune_out.narrow_if_corner == $past(req_in.wdata[NARROW_MSB:NARROW_LSB]))
      else $error("narrow corner did not take write");

   chk_wide_write: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (req_in.wr && req_in.addr == CORNER_OFS) |=>
         tune_out.wide_if_corner == $past(req_in.wdata[WIDE_MSB:0]))
      else $error("wide corner did not take write");

   // checks: read answers, write protection and reset values

   chk_temp_read: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (req_in.rd && req_in.addr == TEMP_OFS) |=>
         rd_valid_out && rd_hit_out && rd_data_out == {3'h0, $past(temp_code)})
      else $error("thermometer read returned wrong value");

   chk_temp_readonly: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (req_in.wr && req_in.addr == TEMP_OFS) |=> $stable(tune_out))
      else $error("write to thermometer changed a tuning code");

   chk_doubler_addr: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (req_in.wr && req_in.addr != DBL_OFS) |=> $stable(tune_out.doubler_filter_tune))
      else $error("doubler code changed by foreign write");

   chk_reserved_read: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (req_in.rd && req_in.addr == DBL_OFS) |=> rd_data_out[7:5] == 3'h0 &&
         rd_data_out[DBL_MSB:0] == $past(tune_out.doubler_filter_tune))
      else $error("doubler readback mismatch");

   chk_reserved_zero: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (req_in.rd && (req_in.addr == FWD_GAIN_OFS || req_in.addr == REV_GAIN_OFS)) |=>
         !rd_data_out[7])
      else $error("reserved gain bit read as one");

   chk_unmapped_read: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (req_in.rd && (req_in.addr < DBL_OFS || req_in.addr > TEMP_OFS)) |=>
         rd_valid_out && !rd_hit_out && rd_data_out == 8'h00)
      else $error("unmapped read not answered with zero");

   chk_reset_zero: assert property (@(posedge clk_sys_in)
      $rose(rstn_in) |-> tune_out == '0)
      else $error("tuning codes not zero after reset");

   // checks: every image but the doubler reads back with its reserved bits at zero

   chk_quad_read: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (req_in.rd && sel_quad) |=>
         rd_data_out == {4'h0, $past(tune_out.quad_filter_tune)})
      else $error("quadrupler readback mismatch");

   chk_fwd_gain_read: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (req_in.rd && sel_fwd) |=>
         rd_data_out == {1'b0, $past(tune_out.forward_if_gain)})
      else $error("forward gain readback mismatch");

   chk_rev_gain_read: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (req_in.rd && sel_rev) |=>
         rd_data_out == {1'b0, $past(tune_out.reverse_if_gain)})
      else $error("reverse gain readback mismatch");

   chk_narrow_read: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (req_in.rd && sel_corner) |=>
         rd_data_out[NARROW_MSB:NARROW_LSB] == $past(tune_out.narrow_if_corner))
      else $error("narrow corner readback mismatch");

   chk_wide_read: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (req_in.rd && sel_corner) |=>
         rd_data_out[WIDE_MSB:0] == $past(tune_out.wide_if_corner))
      else $error("wide corner readback mismatch");

   chk_quad_reserved: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (req_in.rd && sel_quad) |=>
         rd_data_out[7:4] == 4'h0)
      else $error("reserved quadrupler bits read as one");

   chk_temp_reserved: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (req_in.rd && sel_temp) |=>
         rd_data_out[7:5] == 3'h0)
      else $error("reserved thermometer bits read as one");

   // checks: a write, an idle cycle and a read return the masked write data

   chk_doubler_roundtrip: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (req_in.wr && sel_dbl) ##1 !req_in.wr ##1 (req_in.rd && sel_dbl) |=>
         rd_data_out == ($past(req_in.wdata, 3) & DBL_MASK))
      else $error("doubler write not read back masked");

   chk_quad_roundtrip: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (req_in.wr && sel_quad) ##1 !req_in.wr ##1 (req_in.rd && sel_quad) |=>
         rd_data_out == ($past(req_in.wdata, 3) & QUAD_MASK))
      else $error("quadrupler write not read back masked");

   chk_fwd_roundtrip: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (req_in.wr && sel_fwd) ##1 !req_in.wr ##1 (req_in.rd && sel_fwd) |=>
         rd_data_out == ($past(req_in.wdata, 3) & GAIN_MASK))
      else $error("forward gain write not read back masked");

   chk_rev_roundtrip: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (req_in.wr && sel_rev) ##1 !req_in.wr ##1 (req_in.rd && sel_rev) |=>
         rd_data_out == ($past(req_in.wdata, 3) & GAIN_MASK))
      else $error("reverse gain write not read back masked");

   chk_corner_roundtrip: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (req_in.wr && sel_corner) ##1 !req_in.wr ##1 (req_in.rd && sel_corner) |=>
         rd_data_out == ($past(req_in.wdata, 3) & CORNER_MASK))
      else $error("corner write not read back");

   // checks: images hold without a write, read port keeps its timing

   chk_doubler_hold: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      !(req_in.wr && sel_dbl) |=>
         $stable(tune_out.doubler_filter_tune))
      else $error("doubler code moved without a write");

   chk_quad_hold: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      !(req_in.wr && sel_quad) |=>
         $stable(tune_out.quad_filter_tune))
      else $error("quadrupler code moved without a write");

   chk_fwd_gain_hold: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      !(req_in.wr && sel_fwd) |=>
         $stable(tune_out.forward_if_gain))
      else $error("forward gain moved without a write");

   chk_rev_gain_hold: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      !(req_in.wr && sel_rev) |=>
         $stable(tune_out.reverse_if_gain))
      else $error("reverse gain moved without a write");

   chk_narrow_hold: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      !(req_in.wr && sel_corner) |=>
         $stable(tune_out.narrow_if_corner))
      else $error("narrow corner moved without a write");

   chk_wide_hold: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      !(req_in.wr && sel_corner) |=>
         $stable(tune_out.wide_if_corner))
      else $error("wide corner moved without a write");

   chk_unmapped_write: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (req_in.wr && (req_in.addr < DBL_OFS || req_in.addr > TEMP_OFS)) |=>
         $stable(tune_out))
      else $error("unmapped write changed a tuning code");

   chk_valid_pulse: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      req_in.rd |=>
         rd_valid_out)
      else $error("read strobe not answered next cycle");

   chk_valid_idle: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      !req_in.rd |=>
         !rd_valid_out)
      else $error("read valid without a read strobe");

   chk_read_hold: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      !req_in.rd |=>
         $stable(rd_data_out) && $stable(rd_hit_out))
      else $error("read answer moved without a read");

   chk_mapped_hit: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (req_in.rd && req_in.addr >= DBL_OFS && req_in.addr <= TEMP_OFS) |=>
         rd_valid_out && rd_hit_out)
      else $error("mapped read not flagged as hit");

   chk_read_reset_idle: assert property (@(posedge clk_sys_in)
      $rose(rstn_in) |->
         rd_data_out == 8'h00 && !rd_valid_out && !rd_hit_out)
      else $error("read port not idle after reset");

endmodule // lot_reg_bank
`default_nettype wire

// *** bench/lot_host_model.sv ***
// Purpose: host side of the register port, issues one-cycle writes and reads
// Assumes: requests launch on a rising edge and drop on the next one
// Notes:   released address and data lines carry the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module lot_host_model
   import lot_pkg::*;
(
   input  wire logic        clk_sys_in,  // system clock
   output var  lot_req_t    req_out,     // request to the bank
   input  wire logic [7:0]  rd_data_in,  // read data
   input  wire logic        rd_valid_in, // read valid pulse
   input  wire logic        rd_hit_in    // read hit a mapped place
);
   // idle bus at time zero
   initial begin
      req_out = '0;
   end

   // one request for one cycle, then junk on the released lines
   task automatic issue(input logic [7:0] a, input logic [7:0] d, input logic w);
      @(posedge clk_sys_in);
      req_out <= '{addr: a, wdata: d, wr: w, rd: ~w};
      @(posedge clk_sys_in);
      req_out <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
   endtask

   // read answer is taken once the answering edge has landed
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v,
                     output logic h);
      issue(a, 8'h00, 1'b0);
      #1;
      v = rd_valid_in;
      d = rd_data_in;
      h = rd_hit_in;
   endtask
endmodule // lot_host_model
`default_nettype wire

// *** bench/lot_reg_bank_tb.sv ***
// Purpose: self-checking bench for the lo/if tuning register bank
// Assumes: one clock, asynchronous active-low reset
// Notes:   expected values come from the register layout, not the design
`timescale 1ns/1ps
`default_nettype none
module lot_reg_bank_tb;
   import lot_pkg::*;
   logic       clk_sys_in;
   logic       rstn_in;
   logic [4:0] temp_sense_in;
   lot_req_t   req;
   lot_tune_t  tune;
   logic [7:0] rd_data;
   logic       rd_valid;
   logic       rd_hit;
   int         n_fail;
   int         comparisons;
   int         cycles;

   lot_reg_bank u_dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .req_in(req),
      .temp_sense_in(temp_sense_in), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
      .rd_hit_out(rd_hit), .tune_out(tune));
   lot_host_model u_host (.clk_sys_in(clk_sys_in), .req_out(req), .rd_data_in(rd_data),
      .rd_valid_in(rd_valid), .rd_hit_in(rd_hit));

   // clock and hang guard
   initial begin
      clk_sys_in = 1'b0;
      forever #20 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         conclude();
      end
   end

   task automatic conclude();
      if (n_fail == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one read with answer pulse, data and hit judged
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic eh);
      logic [7:0] d;
      logic       v;
      logic       h;
      u_host.rd(a, d, v, h);
      chk({31'h0, v}, 32'h1);
      chk({24'h0, d}, {24'h0, e});
      chk({31'h0, h}, {31'h0, eh});
   endtask

   // every register and code is zero after reset
   task automatic t_reset();
      chk({1'b0, tune}, 32'h0);
      for (int a = 8'h21; a <= 8'h26; a++) begin
         rd_chk(a[7:0], 8'h00, 1'b1);
      end
   endtask

   // all-ones writes keep only the writable bits
   task automatic t_masks();
      logic [7:0] ofs [5] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25};
      logic [7:0] msk [5] = '{8'h1F, 8'h0F, 8'h7F, 8'h7F, 8'hFF};
      for (int i = 0; i < 5; i++) begin
         u_host.issue(ofs[i], 8'hFF, 1'b1);
         rd_chk(ofs[i], msk[i], 1'b1);
      end
      chk({1'b0, tune}, 32'h7FFF_FFFF);
   endtask

   // distinct codes land in their own fields, reserved bits dropped
   task automatic t_fields();
      u_host.issue(8'h23, 8'h12, 1'b1);
      u_host.issue(8'h24, 8'hAA, 1'b1);
      u_host.issue(8'h25, 8'hA5, 1'b1);
      u_host.issue(8'h21, 8'hF5, 1'b1);
      u_host.issue(8'h22, 8'h96, 1'b1);
      rd_chk(8'h25, 8'hA5, 1'b1);
      chk({1'b0, tune}, {1'b0, 5'h15, 4'h6, 7'h12, 7'h2A, 4'hA, 4'h5});
   endtask

   // thermometer is read-only, unmapped places read zero without hit
   task automatic t_temp();
      @(posedge clk_sys_in);
      temp_sense_in <= 5'h13;
      repeat (8) @(posedge clk_sys_in);
      u_host.issue(8'h26, 8'hFF, 1'b1);
      u_host.issue(8'h27, 8'hFF, 1'b1);
      rd_chk(8'h26, 8'h13, 1'b1);
      rd_chk(8'h27, 8'h00, 1'b0);
      rd_chk(8'h20, 8'h00, 1'b0);
      rd_chk(8'h22, 8'h06, 1'b1);
   endtask

   // reset in mid-run clears every image and the read port
   task automatic t_midreset();
      @(posedge clk_sys_in);
      rstn_in <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      chk({1'b0, tune}, 32'h0);
      chk({22'h0, rd_data, rd_valid, rd_hit}, 32'h0);
      rstn_in <= 1'b1;
      rd_chk(8'h25, 8'h00, 1'b1);
      rd_chk(8'h21, 8'h00, 1'b1);
   endtask

   // reset, then the scenarios in turn
   initial begin
      n_fail = 0;
      comparisons = 0;
      cycles = 0;
      rstn_in = 1'b0;
      temp_sense_in = 5'h00;
      repeat (10) @(posedge clk_sys_in);
      rstn_in <= 1'b1;
      t_reset();
      t_masks();
      t_fields();
      t_temp();
      t_midreset();
      conclude();
   end
endmodule // lot_reg_bank_tb
`default_nettype wire
